// File: brtc_pkg.sv
package brtc_pkg;

  // bus address of this slave; the value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2a;

  localparam int REG_COUNT = 64;
  localparam logic [5:0] ADDR_SECONDS = 6'h00;
  localparam logic [5:0] ADDR_MINUTES = 6'h01;
  localparam logic [5:0] ADDR_HOURS = 6'h02;
  localparam logic [5:0] ADDR_WEEKDAY = 6'h03;
  localparam logic [5:0] ADDR_DATE = 6'h04;
  localparam logic [5:0] ADDR_MONTH = 6'h05;
  localparam logic [5:0] ADDR_YEAR = 6'h06;
  localparam logic [5:0] ADDR_CONTROL = 6'h07;
  localparam logic [5:0] ADDR_RAM_FIRST = 6'h08;
  localparam logic [5:0] ADDR_RAM_LAST = 6'h3f;
  localparam logic [5:0] PTR_STEP = 6'h01;

  // field positions
  localparam int CLOCK_HALT_BIT = 7;
  localparam int HOUR_MODE_BIT = 6;
  localparam int MERIDIAN_BIT = 5;
  localparam int OUT_LEVEL_BIT = 7;
  localparam int SQW_ENABLE_BIT = 4;
  localparam int RATE_HIGH_BIT = 1;
  localparam int RATE_LOW_BIT = 0;
  localparam int RX_DIR_BIT = 0;
  localparam int TX_MSB = 7;

  // bcd limits
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] HR24_MAX = 8'h23;
  localparam logic [7:0] HR12_ELEVEN = 8'h11;
  localparam logic [7:0] HR12_TWELVE = 8'h12;
  localparam logic [7:0] HR12_ONE = 8'h01;
  localparam logic [7:0] WDAY_MAX = 8'h07;
  localparam logic [7:0] MON_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [4:0] MON_FEB = 5'h02;
  localparam logic [4:0] MON_APR = 5'h04;
  localparam logic [4:0] MON_JUN = 5'h06;
  localparam logic [4:0] MON_SEP = 5'h09;
  localparam logic [4:0] MON_NOV = 5'h11;
  localparam logic [3:0] DIGIT_NINE = 4'h9;
  localparam logic [3:0] DIGIT_STEP = 4'h1;

  // rate select codes
  localparam logic [1:0] RATE_1HZ = 2'h0;
  localparam logic [1:0] RATE_4K = 2'h1;
  localparam logic [1:0] RATE_8K = 2'h2;
  localparam logic [1:0] RATE_32K = 2'h3;

  // divider taps off the 32.768 khz time base
  localparam int DIV_W = 15;
  localparam int TAP_8K = 1;
  localparam int TAP_4K = 2;
  localparam int TAP_1HZ = 14;
  localparam logic [14:0] DIV_LAST = 15'h7fff;
  localparam logic [14:0] DIV_STEP = 15'h0001;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_STEP = 4'h1;

  typedef enum logic [2:0] {
    BRTC_IDLE,
    BRTC_ADDR,
    BRTC_PTR,
    BRTC_WDATA,
    BRTC_RDATA,
    BRTC_WAIT
  } brtc_state_t;

  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] mem;
    logic [5:0] ptr;
    brtc_state_t st;
    logic [3:0] bitcnt;
    logic ack_phase;
    logic [7:0] shreg;
    logic sda_oe;
    logic scl_q;
    logic sda_q;
    logic xin_q;
    logic [DIV_W-1:0] div;
    logic sqw;
  } brtc_regs_t;

endpackage

// File: brtc_top.sv
`timescale 1ns/1ps
// Operation
// - time and control at 00h to 07h
// - user storage at 08h to 3Fh
// - pointer advances per byte, wraps 3Fh to 00h
// - sec, min, hr, wday, date, month, year, control
// - all time values held in bcd
// - date rolls over by month length, leap february
// - leap compensation valid through 2099
// - halt flag stops time base and counting
// - hours bit 6 high selects 12-hour
// - 12-hour: bit 5 high means afternoon
// - 24-hour: bit 5 is second tens digit
// - control: out level, enable, rate select
// - enable low drives static out level
// - enable high drives oscillator clock, divided except at 32k
// - rates 1 Hz, 4k, 8k, 32k
// - start, address, pointer, sequential until stop
// - power fail aborts, clears pointer, ignores bus
// - timekeeping keeps running under power fail
// - data line open drain, pull low only
// - crystal or external 32.768 kHz time base
// - seven-bit address plus direction bit
// - first write byte loads pointer, rest stored
// - read starts at retained pointer
module brtc_top (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic i_crystal_input,
  input wire logic i_power_fail,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_square_wave_pin
);

  brtc_pkg::brtc_regs_t state_r;
  brtc_pkg::brtc_regs_t state_nxt;
  logic zero_r;

  // carry in bit 8, next value below; out-of-range values restart at lo
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top, input logic [7:0] lo);
    logic [8:0] res;
    res = {1'b0, v};
    if (v >= top) begin
      res = {1'b1, lo};
    end else if (v[3:0] >= brtc_pkg::DIGIT_NINE) begin
      res = {1'b0, 4'(v[7:4] + brtc_pkg::DIGIT_STEP), 4'h0};
    end else begin
      res = {1'b0, v[7:4], 4'(v[3:0] + brtc_pkg::DIGIT_STEP)};
    end
    return res;
  endfunction

  // year 00 counts as leap, right for 2000 to 2099
  function automatic logic is_leap(input logic [7:0] yr);
    logic u048;
    logic u26;
    u048 = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
    u26 = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
    return yr[4] ? u26 : u048;
  endfunction

  function automatic logic [7:0] month_days(input logic [4:0] mon, input logic [7:0] yr);
    logic [7:0] d;
    d = brtc_pkg::DAYS_31;
    if (mon == brtc_pkg::MON_FEB) begin
      d = is_leap(yr) ? brtc_pkg::DAYS_29 : brtc_pkg::DAYS_28;
    end else if (mon == brtc_pkg::MON_APR || mon == brtc_pkg::MON_JUN ||
                 mon == brtc_pkg::MON_SEP || mon == brtc_pkg::MON_NOV) begin
      d = brtc_pkg::DAYS_30;
    end
    return d;
  endfunction

  always_comb begin
    logic halted;
    logic xin_rise;
    logic sec_tick;
    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;
    logic carry;
    logic [8:0] inc;
    logic [7:0] hr;
    logic [7:0] ctl;
    logic [7:0] tx;
    halted = 1'b0;
    xin_rise = 1'b0;
    sec_tick = 1'b0;
    start_cond = 1'b0;
    stop_cond = 1'b0;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    carry = 1'b0;
    inc = 9'h000;
    hr = 8'h00;
    ctl = 8'h00;
    tx = 8'h00;
    state_nxt = state_r;

    // time base: crystal or external clock both arrive on the same input
    state_nxt.xin_q = i_crystal_input;
    halted = state_r.mem[brtc_pkg::ADDR_SECONDS][brtc_pkg::CLOCK_HALT_BIT];
    xin_rise = i_crystal_input & ~state_r.xin_q;
    if (xin_rise && !halted) begin
      state_nxt.div = state_r.div + brtc_pkg::DIV_STEP;
      sec_tick = (state_r.div == brtc_pkg::DIV_LAST);
    end

    // calendar counting; no term looks at the power-fail input here
    if (sec_tick) begin
      inc = bcd_inc({1'b0, state_r.mem[brtc_pkg::ADDR_SECONDS][6:0]}, brtc_pkg::SEC_MAX, brtc_pkg::BCD_ZERO);
      state_nxt.mem[brtc_pkg::ADDR_SECONDS][6:0] = inc[6:0];
      carry = inc[8];
      if (carry) begin
        inc = bcd_inc({1'b0, state_r.mem[brtc_pkg::ADDR_MINUTES][6:0]}, brtc_pkg::MIN_MAX, brtc_pkg::BCD_ZERO);
        state_nxt.mem[brtc_pkg::ADDR_MINUTES][6:0] = inc[6:0];
        carry = inc[8];
      end
      if (carry) begin
        hr = state_r.mem[brtc_pkg::ADDR_HOURS];
        if (hr[brtc_pkg::HOUR_MODE_BIT]) begin
          // 12-hour: bit 5 is meridian, hours 01..12
          if ({3'h0, hr[4:0]} == brtc_pkg::HR12_ELEVEN) begin
            state_nxt.mem[brtc_pkg::ADDR_HOURS][4:0] = brtc_pkg::HR12_TWELVE[4:0];
            state_nxt.mem[brtc_pkg::ADDR_HOURS][brtc_pkg::MERIDIAN_BIT] = ~hr[brtc_pkg::MERIDIAN_BIT];
            carry = hr[brtc_pkg::MERIDIAN_BIT];
          end else if ({3'h0, hr[4:0]} >= brtc_pkg::HR12_TWELVE) begin
            state_nxt.mem[brtc_pkg::ADDR_HOURS][4:0] = brtc_pkg::HR12_ONE[4:0];
            carry = 1'b0;
          end else begin
            inc = bcd_inc({3'h0, hr[4:0]}, brtc_pkg::HR12_TWELVE, brtc_pkg::HR12_ONE);
            state_nxt.mem[brtc_pkg::ADDR_HOURS][4:0] = inc[4:0];
            carry = 1'b0;
          end
        end else begin
          // 24-hour: bit 5 is the twenties digit
          inc = bcd_inc({2'h0, hr[5:0]}, brtc_pkg::HR24_MAX, brtc_pkg::BCD_ZERO);
          state_nxt.mem[brtc_pkg::ADDR_HOURS][5:0] = inc[5:0];
          carry = inc[8];
        end
      end
      if (carry) begin
        inc = bcd_inc({5'h00, state_r.mem[brtc_pkg::ADDR_WEEKDAY][2:0]}, brtc_pkg::WDAY_MAX, brtc_pkg::BCD_ONE);
        state_nxt.mem[brtc_pkg::ADDR_WEEKDAY][2:0] = inc[2:0];
        inc = bcd_inc({2'h0, state_r.mem[brtc_pkg::ADDR_DATE][5:0]},
                      month_days(state_r.mem[brtc_pkg::ADDR_MONTH][4:0], state_r.mem[brtc_pkg::ADDR_YEAR]),
                      brtc_pkg::BCD_ONE);
        state_nxt.mem[brtc_pkg::ADDR_DATE][5:0] = inc[5:0];
        carry = inc[8];
      end
      if (carry) begin
        inc = bcd_inc({3'h0, state_r.mem[brtc_pkg::ADDR_MONTH][4:0]}, brtc_pkg::MON_MAX, brtc_pkg::BCD_ONE);
        state_nxt.mem[brtc_pkg::ADDR_MONTH][4:0] = inc[4:0];
        carry = inc[8];
      end
      if (carry) begin
        inc = bcd_inc(state_r.mem[brtc_pkg::ADDR_YEAR], brtc_pkg::YEAR_MAX, brtc_pkg::BCD_ZERO);
        state_nxt.mem[brtc_pkg::ADDR_YEAR] = inc[7:0];
      end
    end

    // square-wave pin
    ctl = state_r.mem[brtc_pkg::ADDR_CONTROL];
    if (!ctl[brtc_pkg::SQW_ENABLE_BIT]) begin
      state_nxt.sqw = ctl[brtc_pkg::OUT_LEVEL_BIT];
    end else begin
      unique case ({ctl[brtc_pkg::RATE_HIGH_BIT], ctl[brtc_pkg::RATE_LOW_BIT]})
        brtc_pkg::RATE_1HZ: state_nxt.sqw = state_r.div[brtc_pkg::TAP_1HZ];
        brtc_pkg::RATE_4K: state_nxt.sqw = state_r.div[brtc_pkg::TAP_4K];
        brtc_pkg::RATE_8K: state_nxt.sqw = state_r.div[brtc_pkg::TAP_8K];
        brtc_pkg::RATE_32K: state_nxt.sqw = state_r.xin_q & ~halted; // stopped oscillator gives no clock
      endcase
    end

    // serial slave; the master owns clock, start and stop
    state_nxt.scl_q = i_scl;
    state_nxt.sda_q = i_sda_in;
    start_cond = state_r.scl_q && i_scl && state_r.sda_q && !i_sda_in;
    stop_cond = state_r.scl_q && i_scl && !state_r.sda_q && i_sda_in;
    scl_rise = !state_r.scl_q && i_scl;
    scl_fall = state_r.scl_q && !i_scl;
    tx = state_r.mem[state_r.ptr];

    if (i_power_fail) begin
      state_nxt.st = brtc_pkg::BRTC_IDLE;
      state_nxt.ptr = brtc_pkg::ADDR_SECONDS;
      state_nxt.sda_oe = 1'b0;
      state_nxt.ack_phase = 1'b0;
      state_nxt.bitcnt = 4'h0;
    end else if (start_cond) begin
      state_nxt.st = brtc_pkg::BRTC_ADDR;
      state_nxt.bitcnt = 4'h0;
      state_nxt.ack_phase = 1'b0;
      state_nxt.sda_oe = 1'b0;
    end else if (stop_cond) begin
      state_nxt.st = brtc_pkg::BRTC_IDLE;
      state_nxt.ack_phase = 1'b0;
      state_nxt.sda_oe = 1'b0;
    end else if (scl_rise && state_r.st != brtc_pkg::BRTC_IDLE && state_r.st != brtc_pkg::BRTC_WAIT) begin
      if (state_r.ack_phase) begin
        // a high line in the master's ack slot is a nack: stop sending
        if (state_r.st == brtc_pkg::BRTC_RDATA && i_sda_in) begin
          state_nxt.st = brtc_pkg::BRTC_WAIT;
        end
      end else begin
        if (state_r.st != brtc_pkg::BRTC_RDATA) begin
          state_nxt.shreg = {state_r.shreg[6:0], i_sda_in};
        end
        state_nxt.bitcnt = 4'(state_r.bitcnt + brtc_pkg::BIT_STEP);
      end
    end else if (scl_fall) begin
      if (state_r.ack_phase) begin
        state_nxt.ack_phase = 1'b0;
        state_nxt.bitcnt = 4'h0;
        if (state_r.st == brtc_pkg::BRTC_RDATA) begin
          state_nxt.shreg = tx;
          state_nxt.sda_oe = ~tx[brtc_pkg::TX_MSB];
          state_nxt.ptr = 6'(state_r.ptr + brtc_pkg::PTR_STEP);
        end else begin
          state_nxt.sda_oe = 1'b0;
        end
      end else if (state_r.bitcnt == brtc_pkg::BITS_PER_BYTE) begin
        state_nxt.bitcnt = 4'h0;
        unique case (state_r.st)
          brtc_pkg::BRTC_ADDR: begin
            if (state_r.shreg[7:1] == brtc_pkg::DEV_ADDR) begin
              state_nxt.sda_oe = 1'b1;
              state_nxt.ack_phase = 1'b1;
              state_nxt.st = state_r.shreg[brtc_pkg::RX_DIR_BIT] ? brtc_pkg::BRTC_RDATA : brtc_pkg::BRTC_PTR;
            end else begin
              state_nxt.st = brtc_pkg::BRTC_WAIT;
            end
          end
          brtc_pkg::BRTC_PTR: begin
            state_nxt.ptr = state_r.shreg[5:0];
            state_nxt.sda_oe = 1'b1;
            state_nxt.ack_phase = 1'b1;
            state_nxt.st = brtc_pkg::BRTC_WDATA;
          end
          brtc_pkg::BRTC_WDATA: begin
            // a bus write in the same cycle as a tick overrides the count
            state_nxt.mem[state_r.ptr] = state_r.shreg;
            state_nxt.ptr = 6'(state_r.ptr + brtc_pkg::PTR_STEP);
            state_nxt.sda_oe = 1'b1;
            state_nxt.ack_phase = 1'b1;
          end
          brtc_pkg::BRTC_RDATA: begin
            state_nxt.sda_oe = 1'b0;
            state_nxt.ack_phase = 1'b1;
          end
          default: begin
            state_nxt.sda_oe = 1'b0;
          end
        endcase
      end else if (state_r.st == brtc_pkg::BRTC_RDATA && state_r.bitcnt != 4'h0) begin
        state_nxt.shreg = {state_r.shreg[6:0], 1'b0};
        state_nxt.sda_oe = ~state_r.shreg[6];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_r <= '0;
      zero_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      zero_r <= 1'b0;
    end
  end

  // the line is only ever pulled low, the high level comes from the pull-up
  assign o_sda_out = zero_r;
  assign o_sda_oe = state_r.sda_oe;
  assign o_square_wave_pin = state_r.sqw;

endmodule // brtc_top

// File: brtc_top_sva.sv
`timescale 1ns/1ps
module brtc_top_sva (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic i_crystal_input,
  input wire logic i_power_fail,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_square_wave_pin
);
  logic scl_d, sda_d, xin_d, fell_d, first_r;
  logic [3:0] cnt_r, quiet_r;
  logic [7:0] sr_r;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  // own decode of the first byte after start, so acks are judged independently of the slave
  always_ff @(posedge i_mclk) begin
    scl_d <= i_scl;
    sda_d <= i_sda_in;
    xin_d <= i_crystal_input;
    fell_d <= scl_d & ~i_scl;
    if (i_rst || i_power_fail) begin
      first_r <= 1'b0;
      cnt_r <= 4'h0;
    end else if (i_scl && scl_d && sda_d && !i_sda_in) begin
      first_r <= 1'b1;
      cnt_r <= 4'h0;
    end else if (i_scl && !scl_d) begin
      cnt_r <= cnt_r + 4'h1;
      sr_r <= (cnt_r < 4'h8) ? {sr_r[6:0], i_sda_in} : sr_r;
    end else if (!i_scl && scl_d && cnt_r == 4'h9) begin
      first_r <= 1'b0;
    end
    if (i_rst || i_scl != scl_d || i_crystal_input != xin_d) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hf) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  a_sda_out_low: assert property (o_sda_out == 1'b0)
    else $error("data output not low");
  a_pf_abort_bus: assert property ($rose(i_power_fail) |=> !o_sda_oe [*3])
    else $error("data line held after power fail");
  a_pf_ignore_bus: assert property (i_power_fail && $past(i_power_fail) |-> !o_sda_oe)
    else $error("bus answered during power fail");
  a_oe_after_fall: assert property ($changed(o_sda_oe) |-> fell_d || $past(i_power_fail))
    else $error("data line moved away from clock fall");
  a_oe_steady_high: assert property (i_scl && scl_d && !$past(i_power_fail) |-> $stable(o_sda_oe))
    else $error("data line moved while clock high");
  a_addr_ack: assert property (first_r && cnt_r == 4'h8 && !i_scl && scl_d
    |=> o_sda_oe == (sr_r[7:1] == brtc_pkg::DEV_ADDR))
    else $error("address acknowledge wrong");
  a_wr_ack_release: assert property (first_r && cnt_r == 4'h9 && !i_scl && scl_d && !sr_r[0]
    |=> !o_sda_oe)
    else $error("acknowledge not released");
  a_pin_cause: assert property ($changed(o_square_wave_pin) |-> quiet_r < 4'h4)
    else $error("output pin moved without cause");
endmodule // brtc_top_sva
bind brtc_top brtc_top_sva u_sva (.i_mclk(i_mclk), .i_rst(i_rst), .i_scl(i_scl), .i_sda_in(i_sda_in),
  .i_crystal_input(i_crystal_input), .i_power_fail(i_power_fail), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_square_wave_pin(o_square_wave_pin));

// File: brtc_master.sv
`timescale 1ns/1ps
module brtc_master (
  input wire logic i_mclk,
  input wire logic i_oe,
  output logic o_scl,
  output logic o_sda
);
  localparam int PH = 3;
  logic low_r = 1'b0;
  // pull-up: the line is high unless a party pulls it low
  assign o_sda = !(low_r || i_oe);
  initial o_scl = 1'b1;
  task automatic tick();
    repeat (PH) @(posedge i_mclk);
  endtask
  // only the master makes clock, start and stop
  task automatic start();
    low_r <= 1'b0;
    tick();
    o_scl <= 1'b1;
    tick();
    low_r <= 1'b1;
    tick();
    o_scl <= 1'b0;
    tick();
  endtask
  task automatic stop();
    low_r <= 1'b1;
    tick();
    o_scl <= 1'b1;
    tick();
    low_r <= 1'b0;
    tick();
  endtask
  // eight bits msb first then the acknowledge slot; ack_in high withholds it
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    logic [8:0] w;
    w = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      low_r <= !w[i];
      tick();
      o_scl <= 1'b1;
      tick();
      w[i] = o_sda;
      o_scl <= 1'b0;
      tick();
    end
    {rx, ack_out} = w;
  endtask
endmodule // brtc_master

// File: brtc_top_tb_top.sv
`timescale 1ns/1ps
module brtc_top_tb_top;
  typedef struct {logic [7:0] sec; logic [7:0] ctl; int lo; int hi;} brtc_row_t;
  localparam logic [7:0] AW = {brtc_pkg::DEV_ADDR, 1'b0};
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic xtal = 1'b0;
  logic pf = 1'b0;
  logic scl, sda, sda_oe, pin, ak, pl;
  logic [7:0] rx;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  // pin rises in 256 cycles with a crystal rise every 2 cycles; halted rows last
  brtc_row_t rows[8] = '{'{8'h00, 8'h10, 0, 1}, '{8'h00, 8'h11, 15, 17}, '{8'h00, 8'h12, 31, 33},
    '{8'h00, 8'h13, 127, 129}, '{8'h00, 8'h80, 0, 0}, '{8'h00, 8'h00, 0, 0}, '{8'h80, 8'h13, 0, 0},
    '{8'h80, 8'h11, 0, 0}};
  brtc_top u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl), .i_sda_in(sda), .i_crystal_input(xtal),
    .i_power_fail(pf), .o_sda_out(), .o_sda_oe(sda_oe), .o_square_wave_pin(pin));
  brtc_master u_mst (.i_mclk(i_mclk), .i_oe(sda_oe), .o_scl(scl), .o_sda(sda));
  initial begin
    forever #4 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) xtal <= ~xtal;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      bad_count = bad_count + 1;
    end
  endtask
  task automatic wr(input logic [5:0] p, input logic [7:0] d[$]);
    u_mst.start();
    u_mst.xfer(AW, 1'b1, rx, ak);
    chk("wr_ack", 8'h00, {7'h0, ak});
    u_mst.xfer({2'h0, p}, 1'b1, rx, ak);
    foreach (d[i]) begin
      u_mst.xfer(d[i], 1'b1, rx, ak);
      chk("wd_ack", 8'h00, {7'h0, ak});
    end
    u_mst.stop();
  endtask
  task automatic rd(input logic setp, input logic [5:0] p, input logic [7:0] e[$]);
    if (setp) begin
      u_mst.start();
      u_mst.xfer(AW, 1'b1, rx, ak);
      u_mst.xfer({2'h0, p}, 1'b1, rx, ak);
    end
    u_mst.start();
    u_mst.xfer(AW | 8'h01, 1'b1, rx, ak);
    chk("rd_ack", 8'h00, {7'h0, ak});
    foreach (e[i]) begin
      u_mst.xfer(8'hff, i == e.size() - 1, rx, ak);
      chk("rdata", e[i], rx);
    end
    u_mst.stop();
  endtask
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    rd(1'b1, 6'h00, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    wr(6'h3f, '{8'h5a, 8'h00, 8'h17});
    rd(1'b1, 6'h3f, '{8'h5a, 8'h00});
    rd(1'b0, 6'h00, '{8'h17});
    foreach (rows[i]) begin
      wr(6'h00, '{rows[i].sec});
      wr(6'h07, '{rows[i].ctl});
      repeat (8) @(posedge i_mclk);
      n = 0;
      pl = pin;
      repeat (256) begin
        @(posedge i_mclk);
        n = n + ((pin && !pl) ? 1 : 0);
        pl = pin;
      end
      chk("rate", 8'h01, 8'(n >= rows[i].lo && n <= rows[i].hi));
      if (!rows[i].ctl[4]) chk("level", {7'h0, rows[i].ctl[7]}, {7'h0, pin});
      rd(1'b1, 6'h07, '{rows[i].ctl});
    end
    u_mst.start();
    u_mst.xfer(AW ^ 8'h02, 1'b1, rx, ak);
    chk("bad_addr", 8'h01, {7'h0, ak});
    u_mst.stop();
    u_mst.start();
    u_mst.xfer(AW, 1'b1, rx, ak);
    u_mst.xfer(8'h3a, 1'b1, rx, ak);
    pf <= 1'b1;
    u_mst.xfer(8'h77, 1'b1, rx, ak);
    chk("pf_ack", 8'h01, {7'h0, ak});
    pf <= 1'b0;
    u_mst.stop();
    u_mst.start();
    fork
      u_mst.xfer(AW, 1'b1, rx, ak);
      begin
        // power fails while the address acknowledge is being driven
        repeat (74) @(posedge i_mclk);
        pf <= 1'b1;
      end
    join
    chk("pf_abort", 8'h01, {7'h0, ak});
    pf <= 1'b0;
    u_mst.stop();
    rd(1'b0, 6'h00, '{8'h80});
    rd(1'b1, 6'h3a, '{8'h00});
    // halted while loading so no tick lands mid-burst; 11 pm in 12-hour mode on 28 feb 01
    wr(6'h00, '{8'hd9, 8'h59, 8'h71, 8'h07, 8'h28, 8'h02, 8'h01});
    wr(6'h00, '{8'h59});
    repeat (1000) @(posedge i_mclk);
    pf <= 1'b1;
    repeat (2000) @(posedge i_mclk);
    pf <= 1'b0;
    repeat (62600) @(posedge i_mclk);
    rd(1'b1, 6'h00, '{8'h00, 8'h00, 8'h52, 8'h01, 8'h01, 8'h03, 8'h01});
    // reset in mid-run clears the registers and the pointer
    i_rst <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    chk("rst_pin", 8'h00, {7'h0, pin});
    rd(1'b0, 6'h00, '{8'h00, 8'h00, 8'h00});
    print_verdict();
  end
endmodule // brtc_top_tb_top
